// ===== vpp_config_regs.sv
`timescale 1ns/1ps
module vpp_config_regs (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [vpp_pkg::VPP_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [vpp_pkg::VPP_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output vpp_pkg::vpp_cfg_t CFG,
    input wire logic V_BELOW_HALF,
    output logic OUT444_ACTIVE,
    output logic DOWN444_DROP,
    input wire logic [vpp_pkg::VPP_DIFF_W-1:0] FIELD_DIFF,
    input wire logic FIELD_DIFF_VALID,
    output logic PULLDOWN_HIT,
    input vpp_pkg::vpp_pixel_t PIX_IN,
    output vpp_pkg::vpp_pixel_t PIX_OUT
);
    localparam int SUM_W = 22; // room for three products plus offset

    // register storage, one word per register
    logic [31:0] regs_reg [vpp_pkg::VPP_NREG];
    // held write address and data until both have arrived
    logic aw_held_reg;
    logic w_held_reg;
    logic [vpp_pkg::VPP_ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic write_go;
    logic [3:0] wr_idx;
    logic wr_hit;
    logic [3:0] rd_idx;
    logic rd_hit;
    logic below_half;
    logic h_below_half;

    // word index from byte address; hit only inside the mapped span
    function automatic logic [4:0] decode(input logic [vpp_pkg::VPP_ADDR_W-1:0] a);
        logic [vpp_pkg::VPP_ADDR_W-1:0] rel;
        rel = a - vpp_pkg::VPP_OFS_VIDEO_START_POSITION;
        decode = {1'b0, 4'h0};
        if (a >= vpp_pkg::VPP_OFS_VIDEO_START_POSITION
            && a <= vpp_pkg::VPP_OFS_HORIZONTAL_SCALE_CONTROL && a[1:0] == 2'h0)
        begin
            decode = {1'b1, rel[5:2]};
        end
    endfunction

    assign {wr_hit, wr_idx} = decode(awaddr_reg);
    assign {rd_hit, rd_idx} = decode(S_AXI_ARADDR);
    // a write retires once both halves are held and no response is pending
    assign write_go = aw_held_reg && w_held_reg && !S_AXI_BVALID;

    // write address channel: take one address, hold it until the write retires
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
            S_AXI_AWREADY <= 1'b0;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
        end
        else
        begin
            // free the slot on the same edge that the write retires
            if (write_go)
                aw_held_reg <= 1'b0;
            S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY;
        end
    end

    // write data channel: same scheme, independent of address order
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            S_AXI_WREADY <= 1'b0;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_held_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
        end
        else
        begin
            if (write_go)
                w_held_reg <= 1'b0;
            S_AXI_WREADY <= !w_held_reg && !S_AXI_WREADY;
        end
    end

    // write response: error for an address outside the map
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= vpp_pkg::VPP_RESP_OKAY;
        end
        else if (write_go)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? vpp_pkg::VPP_RESP_OKAY : vpp_pkg::VPP_RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
        begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // register words: byte-lane writes, reserved bits masked off
    for (genvar i = 0; i < vpp_pkg::VPP_NREG; i++)
    begin : g_reg
        logic [31:0] lane_mask;
        logic [31:0] word_next;
        assign lane_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                            {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
        assign word_next = ((wdata_reg & lane_mask) | (regs_reg[i] & ~lane_mask))
                           & vpp_pkg::VPP_MASK[i];
        always_ff @(posedge CLOCK or negedge ARST_N)
        begin
            if (!ARST_N)
            begin
                if (i == vpp_pkg::VPP_IX_QUALITY)
                    regs_reg[i] <= vpp_pkg::VPP_QUALITY_RESET;
                else
                    regs_reg[i] <= 32'h00000000;
            end
            else if (write_go && wr_hit && wr_idx == 4'(i))
            begin
                regs_reg[i] <= word_next;
            end
        end
    end

    // read channel: one read at a time, data one cycle after the address
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= vpp_pkg::VPP_RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_hit ? regs_reg[rd_idx] : 32'h00000000;
            S_AXI_RRESP <= rd_hit ? vpp_pkg::VPP_RESP_OKAY : vpp_pkg::VPP_RESP_SLVERR;
        end
        else if (S_AXI_RVALID)
        begin
            // ready is raised again only after the answer is taken
            if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_ARREADY;
        end
    end

    // configuration fields straight from the register flops
    // video horizontal start
    assign CFG.video_start_h = regs_reg[0][vpp_pkg::VPP_POS_H_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.video_start_v = regs_reg[0][vpp_pkg::VPP_POS_V_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.sub_start_h = regs_reg[1][vpp_pkg::VPP_POS_H_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.sub_start_v = regs_reg[1][vpp_pkg::VPP_POS_V_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.video_end_h = regs_reg[2][vpp_pkg::VPP_POS_H_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.video_end_v = regs_reg[2][vpp_pkg::VPP_POS_V_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.sub_end_h_bytes = regs_reg[3][vpp_pkg::VPP_POS_H_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.sub_end_v = regs_reg[3][vpp_pkg::VPP_POS_V_LSB +: vpp_pkg::VPP_POS_W];
    assign CFG.bob_duplicate = regs_reg[vpp_pkg::VPP_IX_EXTCTL][vpp_pkg::VPP_EXT_BOB];
    assign CFG.csc_bt709 = regs_reg[vpp_pkg::VPP_IX_EXTCTL][vpp_pkg::VPP_EXT_CSC];
    assign CFG.up420_filter = regs_reg[vpp_pkg::VPP_IX_EXTCTL][vpp_pkg::VPP_EXT_UP420];
    assign CFG.up422_method = regs_reg[vpp_pkg::VPP_IX_EXTCTL][vpp_pkg::VPP_EXT_UP422_LSB +: 2];
    assign CFG.record_base =
        regs_reg[vpp_pkg::VPP_IX_REC_BASE][vpp_pkg::VPP_BASE_LSB +: vpp_pkg::VPP_BASE_W];
    assign CFG.record_location = regs_reg[vpp_pkg::VPP_IX_REC_BASE][vpp_pkg::VPP_LOC_W-1:0];
    assign CFG.record_stride =
        regs_reg[vpp_pkg::VPP_IX_REC_STRIDE][vpp_pkg::VPP_STRIDE_LSB +: vpp_pkg::VPP_STRIDE_W];
    assign CFG.hscale_enable = regs_reg[vpp_pkg::VPP_IX_HSCALE][vpp_pkg::VPP_HS_EN];
    assign CFG.hscale_function = regs_reg[vpp_pkg::VPP_IX_HSCALE][vpp_pkg::VPP_HS_FUNC_LSB +: 2];
    assign CFG.hscale_factor = regs_reg[vpp_pkg::VPP_IX_HSCALE][vpp_pkg::VPP_HS_FACT_W-1:0];

    // horizontal output below half the source: factor is source over
    // destination for the mild band, so two or more means below half
    always_comb
    begin
        h_below_half = 1'b0;
        if (CFG.hscale_enable)
        begin
            case (CFG.hscale_function)
                vpp_pkg::VPP_HS_UP: h_below_half = 1'b0;
                vpp_pkg::VPP_HS_TO_QUARTER:
                    h_below_half = |CFG.hscale_factor[vpp_pkg::VPP_HS_FACT_W-1:
                                                      vpp_pkg::VPP_HS_FRAC+1];
                default: h_below_half = 1'b1;
            endcase
        end
    end
    // vertical size comes from the vertical scaler, same clock domain
    assign below_half = h_below_half || V_BELOW_HALF;

    // effective format choices, registered for clean outputs
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            OUT444_ACTIVE <= 1'b0;
            DOWN444_DROP <= 1'b1;
        end
        else
        begin
            OUT444_ACTIVE <= regs_reg[vpp_pkg::VPP_IX_EXTCTL][vpp_pkg::VPP_EXT_OUT444]
                             && below_half;
            DOWN444_DROP <= regs_reg[vpp_pkg::VPP_IX_EXTCTL][vpp_pkg::VPP_EXT_DOWN444]
                            || below_half;
        end
    end

    // pull-down detection: field difference against threshold times four
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            PULLDOWN_HIT <= 1'b0;
        end
        else if (FIELD_DIFF_VALID)
        begin
            PULLDOWN_HIT <= FIELD_DIFF > vpp_pkg::VPP_DIFF_W'(
                {regs_reg[vpp_pkg::VPP_IX_QUALITY][vpp_pkg::VPP_THR_LSB +: vpp_pkg::VPP_THR_W],
                 vpp_pkg::VPP_THR_SCALE_SH'(0)});
        end
    end

    // colour adjustment matrix, one output component per row; a single
    // register stage keeps timing simple at the cost of a wide adder
    logic [vpp_pkg::VPP_PIX_W-1:0] adj_out [3];
    for (genvar r = 0; r < 3; r++)
    begin : g_row
        logic signed [vpp_pkg::VPP_COEF_W-1:0] ka;
        logic signed [vpp_pkg::VPP_COEF_W-1:0] kb;
        logic signed [vpp_pkg::VPP_COEF_W-1:0] kc;
        logic signed [vpp_pkg::VPP_COEF_W-1:0] kd;
        logic signed [SUM_W-1:0] sum;
        logic signed [SUM_W-1:0] whole;
        assign ka = regs_reg[vpp_pkg::VPP_IX_MATRIX0 + r][0 +: vpp_pkg::VPP_COEF_W];
        assign kb =
            regs_reg[vpp_pkg::VPP_IX_MATRIX0 + r][vpp_pkg::VPP_COEF_W +: vpp_pkg::VPP_COEF_W];
        assign kc =
            regs_reg[vpp_pkg::VPP_IX_MATRIX0 + r][2*vpp_pkg::VPP_COEF_W +: vpp_pkg::VPP_COEF_W];
        assign kd =
            regs_reg[vpp_pkg::VPP_IX_OFFSETS][r*vpp_pkg::VPP_COEF_W +: vpp_pkg::VPP_COEF_W];
        // matrix sum plus offset
        // operands widened first so no product is cut at coefficient width
        assign sum = SUM_W'(ka) * SUM_W'($signed({1'b0, PIX_IN.c1}))
                   + SUM_W'(kb) * SUM_W'($signed({1'b0, PIX_IN.c2}))
                   + SUM_W'(kc) * SUM_W'($signed({1'b0, PIX_IN.c3}))
                   + (SUM_W'(kd) <<< (vpp_pkg::VPP_COEF_FRAC - vpp_pkg::VPP_OFFS_FRAC));
        assign whole = sum >>> vpp_pkg::VPP_COEF_FRAC;
        // clamp to the pixel range rather than wrap
        assign adj_out[r] = (whole < 0) ? '0 :
                            (whole > SUM_W'({vpp_pkg::VPP_PIX_W{1'b1}})) ? '1 :
                            whole[vpp_pkg::VPP_PIX_W-1:0];
    end

    // pixel output stage: adjusted or passed through
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            PIX_OUT <= '0;
        end
        else if (regs_reg[vpp_pkg::VPP_IX_EXTCTL][vpp_pkg::VPP_EXT_ADJ_EN])
        begin
            PIX_OUT <= {PIX_IN.valid, adj_out[0], adj_out[1], adj_out[2]};
        end
        else
        begin
            PIX_OUT <= PIX_IN;
        end
    end
endmodule

// ===== vpp_config_regs_assertions.sv
`timescale 1ns/1ps
module vpp_config_regs_checker (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire vpp_pkg::vpp_cfg_t CFG,
    input wire logic V_BELOW_HALF,
    input wire logic OUT444_ACTIVE,
    input wire logic DOWN444_DROP,
    input wire logic [15:0] FIELD_DIFF,
    input wire logic FIELD_DIFF_VALID,
    input wire logic PULLDOWN_HIT,
    input wire vpp_pkg::vpp_pixel_t PIX_IN,
    input wire vpp_pkg::vpp_pixel_t PIX_OUT
);
    // size decision rebuilt from the live fields; factor 2.0 and up means below half
    logic below_half;
    assign below_half = V_BELOW_HALF || (CFG.hscale_enable && (CFG.hscale_function[1] ||
        (CFG.hscale_function == 2'h1 && CFG.hscale_factor[14:13] != 2'h0)));
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    // write answer stands two edges after a joint address and data hand-over
    wr_answer_a: assert property ((S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
        S_AXI_WREADY && !S_AXI_BVALID) |-> ##2 S_AXI_BVALID) else $error("write answer missing");
    bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID &&
        $stable(S_AXI_BRESP)) else $error("write answer dropped early");
    wr_busy_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> (!S_AXI_AWREADY) [*2])
        else $error("address taken early");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer missing");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID &&
        $stable(S_AXI_RDATA)) else $error("read data changed while waiting");
    rd_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read overlap");
    // unmapped places answer with a zero word
    err_zero_a: assert property (
        S_AXI_RVALID && S_AXI_RRESP == vpp_pkg::VPP_RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
        else $error("error read not zero");
    pix_lat_a: assert property (PIX_IN.valid |=> PIX_OUT.valid) else $error("pixel lost");
    drop_half_a: assert property (below_half |=> DOWN444_DROP) else $error("no drop");
    out444_gate_a: assert property (!below_half |=> !OUT444_ACTIVE) else $error("444 leak");
    // largest threshold is 7 x 4, so anything above 28 must hit
    pd_big_a: assert property (FIELD_DIFF_VALID && FIELD_DIFF > 16'h001c |=> PULLDOWN_HIT)
        else $error("pull-down missed");
    pd_zero_a: assert property (FIELD_DIFF_VALID && FIELD_DIFF == 16'h0 |=> !PULLDOWN_HIT)
        else $error("pull-down false hit");
    pd_hold_a: assert property (!FIELD_DIFF_VALID |=> $stable(PULLDOWN_HIT))
        else $error("pull-down flag moved");
    // main scenarios reached
    cover property (S_AXI_BVALID && !S_AXI_BREADY);
    cover property (S_AXI_RVALID && S_AXI_RRESP == vpp_pkg::VPP_RESP_SLVERR);
    cover property (below_half ##1 OUT444_ACTIVE);
    cover property ($rose(PULLDOWN_HIT));
endmodule
bind vpp_config_regs vpp_config_regs_checker u_chk (.CLOCK, .ARST_N, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .CFG, .V_BELOW_HALF, .OUT444_ACTIVE, .DOWN444_DROP,
    .FIELD_DIFF, .FIELD_DIFF_VALID, .PULLDOWN_HIT, .PIX_IN, .PIX_OUT);

// ===== vpp_config_regs_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, (got), (exp)); end end
module vpp_config_regs_bench;
    localparam logic [11:0] EXT = vpp_pkg::VPP_OFS_EXTENDED_FORMAT_CONTROL;
    localparam logic [11:0] HSC = vpp_pkg::VPP_OFS_HORIZONTAL_SCALE_CONTROL;
    localparam logic [11:0] TUNE = vpp_pkg::VPP_OFS_QUALITY_TUNING_PARAMS;
    localparam logic [1:0] ERR = vpp_pkg::VPP_RESP_SLVERR;
    // scale settings and the expected 444 and drop decisions, one bit per entry
    localparam logic [31:0] HS_TAB [10] = '{32'h0, 32'h90002000, 32'h90001fff, 32'h10002000,
        32'ha0000000, 32'hb0000000, 32'h80000000, 32'h0, 32'h0, 32'h0};
    localparam logic [9:0] OUT_E = 10'h0b2;
    localparam logic [9:0] DROP_E = 10'h3b2;
    logic clock, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, vbh, out444, drop, fvalid, hit;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] fdiff;
    vpp_pkg::vpp_cfg_t cfg;
    vpp_pkg::vpp_pixel_t pin, pout;
    bit slow; // late ready, to see answers held
    int mismatches, check_count;
    vpp_config_regs dut (.CLOCK(clock), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .CFG(cfg), .V_BELOW_HALF(vbh), .OUT444_ACTIVE(out444),
        .DOWN444_DROP(drop), .FIELD_DIFF(fdiff), .FIELD_DIFF_VALID(fvalid),
        .PULLDOWN_HIT(hit), .PIX_IN(pin), .PIX_OUT(pout));
    // free-running 200 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic end_sim();
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one write; valids held until taken, answer code compared
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw;
        bit w;
        int n;
        aw = 1;
        w = 1;
        n = 0;
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= !slow;
        while ((aw || w) && n < 64)
        begin
            @(posedge clock);
            n++;
            if (aw && awready)
            begin
                aw = 0;
                awvalid <= 1'b0;
            end
            if (w && wready)
            begin
                w = 0;
                wvalid <= 1'b0;
            end
        end
        if (slow)
        begin
            repeat (3) @(posedge clock);
            bready <= 1'b1;
        end
        do @(posedge clock); while (!bvalid && n++ < 64);
        bready <= 1'b0;
        `CHK(bresp, er)
        if (n >= 64)
            mismatches++;
    endtask
    // one read; data and answer code compared at the hand-over edge
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !slow;
        do @(posedge clock); while (!arready && n++ < 64);
        arvalid <= 1'b0;
        if (slow)
        begin
            repeat (3) @(posedge clock);
            rready <= 1'b1;
        end
        do @(posedge clock); while (!rvalid && n++ < 64);
        rready <= 1'b0;
        `CHK(rdata, ed)
        `CHK(rresp, er)
        if (n >= 64)
            mismatches++;
    endtask
    // reset words of the whole map, fields all clear
    task automatic t_reset();
        for (int i = 0; i < 13; i++)
            rd(12'h380 + 12'(4 * i), (i == 4) ? 32'h46648688 : 32'h0, 2'h0);
        `CHK(cfg, vpp_pkg::vpp_cfg_t'('0))
    endtask
    // all-ones everywhere: only the writable bits may stick
    task automatic t_mask();
        for (int i = 0; i < 13; i++)
        begin
            slow = i[0];
            wr(12'h380 + 12'(4 * i), 32'hffffffff, 2'h0);
            rd(12'h380 + 12'(4 * i), vpp_pkg::VPP_MASK[i], 2'h0);
        end
        slow = 0;
        `CHK(cfg.video_start_h, 11'h7ff)
        `CHK(cfg.sub_end_h_bytes, 11'h7ff)
        `CHK(cfg.record_base, 25'h1ffffff)
        `CHK(cfg.record_location, 2'h3)
        `CHK(cfg.record_stride, 6'h3f)
        `CHK(cfg.hscale_factor, 15'h7fff)
        wr(vpp_pkg::VPP_OFS_VIDEO_END_POSITION, 32'h01230456, 2'h0);
        `CHK(cfg.video_end_h, 11'h123)
        `CHK(cfg.video_end_v, 11'h456)
        // placement restarts from the picture corner
        wr(vpp_pkg::VPP_OFS_VIDEO_START_POSITION, 32'h0, 2'h0);
        wr(12'h3b4, 32'hffffffff, ERR);
        rd(12'h3b4, 32'h0, ERR);
        rd(12'h37c, 32'h0, ERR);
    endtask
    // every code of the bob, colour space and upsample fields
    task automatic t_ext();
        logic [1:0] c;
        for (int k = 0; k < 4; k++)
        begin
            c = 2'(k);
            wr(EXT, {25'h0, c[0], 1'b0, c[1], c[0], c, 1'b0}, 2'h0);
            `CHK(cfg.bob_duplicate, c[0])
            `CHK(cfg.csc_bt709, c[1])
            `CHK(cfg.up420_filter, c[0])
            `CHK(cfg.up422_method, c)
        end
    endtask
    // below-half decision from scale settings and the vertical flag
    task automatic t_half();
        for (int k = 0; k < 10; k++)
        begin
            wr(EXT, (k == 8) ? 32'h0 : (k == 9) ? 32'h1 : 32'h20, 2'h0);
            wr(HSC, HS_TAB[k], 2'h0);
            @(posedge clock);
            vbh <= (k == 7 || k == 8);
            repeat (2) @(posedge clock);
            `CHK(out444, OUT_E[k])
            `CHK(drop, DROP_E[k])
            `CHK(cfg.hscale_enable, HS_TAB[k][31])
            `CHK(cfg.hscale_function, HS_TAB[k][29:28])
        end
        vbh <= 1'b0;
    endtask
    // one field difference pulse; data scrambled once the pulse ends
    task automatic pd(input logic [15:0] d, input logic e);
        @(posedge clock);
        fdiff <= d;
        fvalid <= 1'b1;
        @(posedge clock);
        fvalid <= 1'b0;
        fdiff <= ~d;
        @(posedge clock);
        `CHK(hit, e)
    endtask
    // two pixels back to back, then idle
    task automatic pix(input logic [23:0] a, b, ea, eb);
        @(posedge clock);
        pin <= {1'b1, a};
        @(posedge clock);
        pin <= {1'b1, b};
        @(posedge clock);
        pin <= {1'b0, ~b};
        `CHK(pout, {1'b1, ea})
        @(posedge clock);
        `CHK(pout, {1'b1, eb})
    endtask
    initial
    begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial
    begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, vbh, fvalid, slow} = '0;
        {awaddr, araddr, wdata, fdiff, pin} = '0;
        wstrb = 4'hf;
        mismatches = 0;
        check_count = 0;
        repeat (5) @(posedge clock);
        `CHK(drop, 1'b1)
        arst_n <= 1'b1;
        t_reset();
        t_mask();
        t_ext();
        t_half();
        // default threshold 4 scales to 16, strict compare
        wr(TUNE, vpp_pkg::VPP_QUALITY_RESET, 2'h0);
        pd(16'd16, 1'b0);
        pd(16'd17, 1'b1);
        pd(16'h0100, 1'b1);
        wr(TUNE, 32'h06648688, 2'h0);
        pd(16'd1, 1'b1);
        pd(16'd0, 1'b0);
        wr(EXT, 32'h0, 2'h0);
        pix(24'h123456, 24'hff0080, 24'h123456, 24'hff0080);
        // identity rows, a negative s2.7 term, offsets +2.0 and -1.0
        wr(vpp_pkg::VPP_OFS_COLOR_MATRIX_ROW1, 32'h00000080, 2'h0);
        wr(vpp_pkg::VPP_OFS_COLOR_MATRIX_ROW2, 32'h00020000, 2'h0);
        wr(vpp_pkg::VPP_OFS_COLOR_MATRIX_ROW3, 32'h08000380, 2'h0);
        wr(vpp_pkg::VPP_OFS_COLOR_MATRIX_OFFSETS, 32'h000ff804, 2'h0);
        wr(EXT, 32'h80, 2'h0);
        pix(24'h100050, 24'hff3450, 24'h120040, 24'hff3300);
        end_sim();
    end
endmodule

// ===== vpp_pkg.sv
// Contract
// - video start holds 11-bit horizontal pixel position
// - video end holds horizontal and vertical position
// - sub-picture end: bytes horizontally, lines vertically
// - tuning resets to word; threshold x4 compare
// - colour adjust: A*c1 + B*c2 + C*c3 + D
// - multiplier coefficient is signed s2.7
// - offset coefficient is signed s8.1
// - bob: average lines at 0, duplicate at 1
// - 444 out only when scaled below half
// - colour space: BT601 at 0, BT709 at 1
// - 420 upsample: 4-tap at 0, filter at 1
// - 422 upsample field: 00 one, 1x filter
// - 444 to 422: average or drop, else drop
// - record base bits 28:4, location bits 1:0
// - record stride six bits at 9:4
// - horizontal scale gated by bit 31, function field
// - horizontal factor unsigned 3.12 fixed point
package vpp_pkg;
    localparam int VPP_NREG = 13;
    localparam int VPP_ADDR_W = 12;
    // register byte offsets
    localparam logic [11:0] VPP_OFS_VIDEO_START_POSITION = 12'h380;
    localparam logic [11:0] VPP_OFS_SUBPICTURE_START_POSITION = 12'h384;
    localparam logic [11:0] VPP_OFS_VIDEO_END_POSITION = 12'h388;
    localparam logic [11:0] VPP_OFS_SUBPICTURE_END_POSITION = 12'h38c;
    localparam logic [11:0] VPP_OFS_QUALITY_TUNING_PARAMS = 12'h390;
    localparam logic [11:0] VPP_OFS_EXTENDED_FORMAT_CONTROL = 12'h394;
    localparam logic [11:0] VPP_OFS_STATIC_RECORD_BASE = 12'h398;
    localparam logic [11:0] VPP_OFS_STATIC_RECORD_STRIDE = 12'h39c;
    localparam logic [11:0] VPP_OFS_COLOR_MATRIX_ROW1 = 12'h3a0;
    localparam logic [11:0] VPP_OFS_COLOR_MATRIX_ROW2 = 12'h3a4;
    localparam logic [11:0] VPP_OFS_COLOR_MATRIX_ROW3 = 12'h3a8;
    localparam logic [11:0] VPP_OFS_COLOR_MATRIX_OFFSETS = 12'h3ac;
    localparam logic [11:0] VPP_OFS_HORIZONTAL_SCALE_CONTROL = 12'h3b0;
    // register indices, word order from the first offset
    localparam int VPP_IX_QUALITY = 4;
    localparam int VPP_IX_EXTCTL = 5;
    localparam int VPP_IX_REC_BASE = 6;
    localparam int VPP_IX_REC_STRIDE = 7;
    localparam int VPP_IX_MATRIX0 = 8;
    localparam int VPP_IX_OFFSETS = 11;
    localparam int VPP_IX_HSCALE = 12;
    // writable bits per register; everything else is reserved
    localparam logic [31:0] VPP_MASK [VPP_NREG] = '{
        32'h07ff07ff, 32'h07ff07ff, 32'h07ff07ff, 32'h07ff07ff,
        32'h77ffffff, 32'h000000ff, 32'h1ffffff3, 32'h000003f0,
        32'h3fffffff, 32'h3fffffff, 32'h3fffffff, 32'h3fffffff,
        32'hb0007fff};
    localparam logic [31:0] VPP_QUALITY_RESET = 32'h46648688;
    // field layout
    localparam int VPP_POS_W = 11;
    localparam int VPP_POS_H_LSB = 16;
    localparam int VPP_POS_V_LSB = 0;
    localparam int VPP_THR_LSB = 28;
    localparam int VPP_THR_W = 3;
    localparam int VPP_THR_SCALE_SH = 2;
    localparam int VPP_EXT_ADJ_EN = 7;
    localparam int VPP_EXT_BOB = 6;
    localparam int VPP_EXT_OUT444 = 5;
    localparam int VPP_EXT_CSC = 4;
    localparam int VPP_EXT_UP420 = 3;
    localparam int VPP_EXT_UP422_LSB = 1;
    localparam int VPP_EXT_DOWN444 = 0;
    localparam int VPP_BASE_LSB = 4;
    localparam int VPP_BASE_W = 25;
    localparam int VPP_LOC_W = 2;
    localparam int VPP_STRIDE_LSB = 4;
    localparam int VPP_STRIDE_W = 6;
    localparam int VPP_COEF_W = 10;
    localparam int VPP_COEF_FRAC = 7;
    localparam int VPP_OFFS_FRAC = 1;
    localparam int VPP_HS_EN = 31;
    localparam int VPP_HS_FUNC_LSB = 28;
    localparam int VPP_HS_FACT_W = 15;
    localparam int VPP_HS_FRAC = 12;
    localparam int VPP_PIX_W = 8;
    localparam int VPP_DIFF_W = 16;
    // horizontal scale function codes
    localparam logic [1:0] VPP_HS_UP = 2'h0;
    localparam logic [1:0] VPP_HS_TO_QUARTER = 2'h1;
    // axi responses
    localparam logic [1:0] VPP_RESP_OKAY = 2'h0;
    localparam logic [1:0] VPP_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [VPP_POS_W-1:0] video_start_h;
        logic [VPP_POS_W-1:0] video_start_v;
        logic [VPP_POS_W-1:0] sub_start_h;
        logic [VPP_POS_W-1:0] sub_start_v;
        logic [VPP_POS_W-1:0] video_end_h;
        logic [VPP_POS_W-1:0] video_end_v;
        logic [VPP_POS_W-1:0] sub_end_h_bytes;
        logic [VPP_POS_W-1:0] sub_end_v;
        logic bob_duplicate;
        logic csc_bt709;
        logic up420_filter;
        logic [1:0] up422_method;
        logic [VPP_BASE_W-1:0] record_base;
        logic [VPP_LOC_W-1:0] record_location;
        logic [VPP_STRIDE_W-1:0] record_stride;
        logic hscale_enable;
        logic [1:0] hscale_function;
        logic [VPP_HS_FACT_W-1:0] hscale_factor;
    } vpp_cfg_t;

    typedef struct packed {
        logic valid;
        logic [VPP_PIX_W-1:0] c1;
        logic [VPP_PIX_W-1:0] c2;
        logic [VPP_PIX_W-1:0] c3;
    } vpp_pixel_t;
endpackage
